/* rtl/lpddr_cmd_pkg.sv */
// constants and types shared by the controller end and the memory end
// assumes one 40 MHz clock and synchronous, active-low reset in both ends
package lpddr_cmd_pkg;

  localparam int CLOCK_MHZ      = 40;
  localparam int BANKS          = 4;
  localparam int BANK_W         = 2;
  localparam int ADDR_W         = 13;
  localparam int DATA_W         = 16;
  localparam int MASK_W         = 2;
  localparam int AP_BIT         = 10;
  localparam int COL_W          = 10;
  localparam int MEM_DEPTH      = 16;
  localparam int MEM_IDX_W      = 4;
  localparam int BURST_LEN      = 4;
  localparam int EXIT_CNT_W     = 8;

  // exit times in ns; plain defaults, the real figures are not supplied
  localparam int POWER_DOWN_EXIT_TIME_NS   = 75;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 200;
  // least times round up to whole 25 ns cycles
  localparam int POWER_DOWN_EXIT_CYCLES    =
    (POWER_DOWN_EXIT_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SELF_REFRESH_EXIT_CYCLES  =
    (SELF_REFRESH_EXIT_TIME_NS * CLOCK_MHZ + 999) / 1000;

  // reset values and mode register bank selects
  localparam logic [ADDR_W-1:0] MODE_RESET     = 13'h0000;
  localparam logic [ADDR_W-1:0] EXT_MODE_RESET = 13'h0000;
  localparam logic [1:0]        MRS_BASE_SEL   = 2'h0;
  localparam logic [1:0]        MRS_EXT_SEL    = 2'h2;

  // {csN, rasN, casN, weN}
  typedef enum logic [3:0] {
    CMD_NOP       = 4'h7,
    CMD_ACTIVATE  = 4'h3,
    CMD_READ      = 4'h5,
    CMD_WRITE     = 4'h4,
    CMD_TERMINATE = 4'h6,
    CMD_PRECHARGE = 4'h2,
    CMD_REFRESH   = 4'h1,
    CMD_MODE_SET  = 4'h0,
    CMD_DESELECT  = 4'h8
  } cmd_t;

  // per-bank state, gray along idle -> active -> read -> write
  typedef enum logic [1:0] {
    BANK_IDLE   = 2'h0,
    BANK_ACTIVE = 2'h1,
    BANK_READ   = 2'h3,
    BANK_WRITE  = 2'h2
  } bank_state_t;

  // device power state, gray along the usual path
  typedef enum logic [2:0] {
    PWR_ON         = 3'h0,
    PWR_PRE_DOWN   = 3'h1,
    PWR_ACT_DOWN   = 3'h3,
    PWR_SELF_REF   = 3'h2,
    PWR_DEEP_DOWN  = 3'h6
  } power_state_t;

  // deselect and nop decode to one code
  function automatic cmd_t decodeCmd(input logic [3:0] pins);
    if (pins[3]) begin
      return CMD_NOP;
    end
    return cmd_t'(pins);
  endfunction

endpackage : lpddr_cmd_pkg

/* rtl/lpddr_link_if.sv */
// pins between the memory controller and the memory device
// assumes both ends share clock; dq is split into in/out/enable per end
`timescale 1ns/1ps
`default_nettype none
interface lpddr_link_if;
  import lpddr_cmd_pkg::*;

  logic                 clockP;
  logic                 clockN;
  logic                 clockEnable;
  logic                 chipSelectN;
  logic                 rasN;
  logic                 casN;
  logic                 weN;
  logic [BANK_W-1:0]    bankAddr;
  logic [ADDR_W-1:0]    addr;
  logic [MASK_W-1:0]    dataMask;
  logic [DATA_W-1:0]    dqFromCtrl;
  logic                 dqCtrlOe;
  logic [DATA_W-1:0]    dqFromMem;
  logic                 dqMemOe;
  logic [DATA_W-1:0]    dqWire;

  // resolved bus level seen by both ends
  assign dqWire = dqCtrlOe ? dqFromCtrl : (dqMemOe ? dqFromMem : '0);

  modport controller (
    output clockP, clockN, clockEnable, chipSelectN, rasN, casN, weN,
    output bankAddr, addr, dataMask, dqFromCtrl, dqCtrlOe,
    input  dqWire, dqMemOe
  );

  modport memory (
    input  clockP, clockN, clockEnable, chipSelectN, rasN, casN, weN,
    input  bankAddr, addr, dataMask, dqWire, dqCtrlOe,
    output dqFromMem, dqMemOe
  );
endinterface : lpddr_link_if
`default_nettype wire

/* rtl/lpddr_memory_end.sv */
// command decode and state tracking of the low-power memory device end
// assumes link pins synchronous to clock; the controller keeps its own duties
//
// Summary of operation
// [R1] a10 on read/write picks auto precharge, per command
// [R2] controller terminates only non-autoprecharge read bursts
// [R3] terminate encoding with cke low enters deep sleep
// [R4] precharge a10 low one bank, high all
// [R5] refresh with cke high auto, low self refresh
// [R6] refresh ignores address and data inputs
// [R7] controller precharges all banks before any refresh
// [R8] bank bits select base or extended mode register
// [R9] write element stored when mask low, dropped high
// [R10] cke sampled each edge against previous edge
// [R11] cke low twice holds the power state
// [R12] cke rising exits low power with nop
// [R13] cke falling enters precharge or active power down
// [R14] controller waits power down exit time after exit
// [R15] controller waits self refresh exit time after exit
// [R16] deselect and nop behave the same everywhere
// [R17] idle bank accepts activate, refresh, mode set
// [R18] open row accepts read, write, precharge
// [R19] read burst: read, write, terminate, precharge allowed
// [R20] write burst: read, write, precharge allowed
// [R21] controller never issues undefined combinations
// [R22] inputs captured on rising edge of true clock
// [R23] extended mode register kept until deep sleep
// [R24] exit times are counts; early commands are flagged
`timescale 1ns/1ps
`default_nettype none
module lpddr_memory_end
  import lpddr_cmd_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  lpddr_link_if.memory               link,
  output logic [ADDR_W-1:0]          modeReg,
  output logic [ADDR_W-1:0]          extModeReg,
  output logic [3:0]                 powerState,
  output logic [2*BANKS-1:0]         bankStates,
  output logic [BANKS-1:0]           autoPrechargeOn,
  output logic                       exitViolation
);

  ////////////////////////////////////////////////////////////////////////
  // command decode; sampling on clock stands for the true-clock rise
  cmd_t                    cmd;
  logic                    ckeNow;
  logic                    ckePrev_q;
  logic                    apBit;
  logic                    ckeHigh;
  assign cmd     = decodeCmd({link.chipSelectN, link.rasN, link.casN, link.weN}); // see [R22]
  assign ckeNow  = link.clockEnable;
  assign apBit   = link.addr[AP_BIT];
  assign ckeHigh = ckePrev_q & ckeNow;

  // previous-edge clock enable, compared each edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ckePrev_q <= 1'b1;
    end else begin
      ckePrev_q <= ckeNow;  // see [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state machine
  power_state_t            power_q;
  bank_state_t             bank_q [BANKS];
  logic                    allIdle;
  logic                    anyOpen;
  logic                    isNop;
  assign isNop = (cmd == CMD_NOP);  // see [R16]

  always_comb begin
    allIdle = 1'b1;
    for (int b = 0; b < BANKS; b++) begin
      if (bank_q[b] != BANK_IDLE) begin
        allIdle = 1'b0;
      end
    end
    anyOpen = !allIdle;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      power_q <= PWR_ON;
    end else if (!ckePrev_q && !ckeNow) begin
      power_q <= power_q;  // see [R11]
    end else if (!ckePrev_q && ckeNow) begin
      if (isNop) begin
        power_q <= PWR_ON;  // see [R12]
      end
    end else if (ckePrev_q && !ckeNow && power_q == PWR_ON) begin
      case (cmd)
        CMD_NOP:       power_q <= anyOpen ? PWR_ACT_DOWN : PWR_PRE_DOWN;  // see [R13]
        CMD_REFRESH:   power_q <= allIdle ? PWR_SELF_REF : power_q;       // see [R5]
        CMD_TERMINATE: power_q <= allIdle ? PWR_DEEP_DOWN : power_q;      // see [R3]
        default:       power_q <= power_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // exit timing: count down after leaving power down or self refresh
  logic [EXIT_CNT_W-1:0]   exitCnt_q;
  logic                    exitViol_q;
  logic                    exitEdge;
  assign exitEdge = !ckePrev_q && ckeNow && isNop;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      exitCnt_q <= '0;
    end else if (exitEdge && power_q == PWR_SELF_REF) begin
      exitCnt_q <= EXIT_CNT_W'(SELF_REFRESH_EXIT_CYCLES);  // see [R24]
    end else if (exitEdge && (power_q == PWR_PRE_DOWN || power_q == PWR_ACT_DOWN)) begin
      exitCnt_q <= EXIT_CNT_W'(POWER_DOWN_EXIT_CYCLES);    // see [R24]
    end else if (exitCnt_q != '0) begin
      exitCnt_q <= exitCnt_q - 1'b1;
    end
  end

  // sticky flag for commands inside the exit window; cleared only by reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      exitViol_q <= 1'b0;
    end else if (exitCnt_q != '0 && ckeHigh && !isNop) begin
      exitViol_q <= 1'b1;  // see [R24]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-bank states; only act when cke high on both edges and powered on
  logic [BANKS-1:0]        ap_q;
  logic                    live;
  assign live = ckeHigh && power_q == PWR_ON;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int b = 0; b < BANKS; b++) begin
        bank_q[b] <= BANK_IDLE;
      end
      ap_q <= '0;
    end else if (live) begin
      for (int b = 0; b < BANKS; b++) begin
        if (BANK_W'(b) == link.bankAddr || (cmd == CMD_PRECHARGE && apBit)) begin
          case (cmd)
            CMD_ACTIVATE: begin
              if (bank_q[b] == BANK_IDLE) begin
                bank_q[b] <= BANK_ACTIVE;  // see [R17]
              end
            end
            CMD_READ: begin
              if (bank_q[b] != BANK_IDLE) begin
                // auto precharge returns the bank to idle on the command edge itself, not after the burst
                bank_q[b] <= apBit ? BANK_IDLE : BANK_READ;  // see [R1] [R18] [R19] [R20]
                ap_q[b]   <= apBit;                          // see [R1]
              end
            end
            CMD_WRITE: begin
              if (bank_q[b] != BANK_IDLE) begin
                bank_q[b] <= apBit ? BANK_IDLE : BANK_WRITE;  // see [R1] [R18] [R19] [R20]
                ap_q[b]   <= apBit;
              end
            end
            CMD_PRECHARGE: begin
              bank_q[b] <= BANK_IDLE;  // see [R4] [R19] [R20]
              ap_q[b]   <= 1'b0;
            end
            default: begin
              bank_q[b] <= bank_q[b];  // see [R6]
            end
          endcase
        end
        // terminate is not bank specific: ends any read burst
        if (cmd == CMD_TERMINATE && bank_q[b] == BANK_READ) begin
          bank_q[b] <= BANK_ACTIVE;  // see [R19]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode registers; refresh never looks at address lines
  logic [ADDR_W-1:0]       mode_q;
  logic [ADDR_W-1:0]       extMode_q;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mode_q    <= MODE_RESET;
      extMode_q <= EXT_MODE_RESET;
    end else if (power_q == PWR_DEEP_DOWN) begin
      extMode_q <= EXT_MODE_RESET;  // see [R23]
    end else if (live && cmd == CMD_MODE_SET && allIdle) begin
      if (link.bankAddr == MRS_BASE_SEL) begin
        mode_q <= link.addr;  // see [R8]
      end else if (link.bankAddr == MRS_EXT_SEL) begin
        extMode_q <= link.addr;  // see [R8] [R23]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // small write store: masked lanes left untouched; refresh touches nothing
  logic [DATA_W-1:0]       mem_q [MEM_DEPTH];
  logic [MEM_IDX_W-1:0]    wrIdx_q;
  logic [2:0]              wrLeft_q;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrLeft_q <= '0;
      wrIdx_q  <= '0;
    end else if (live && cmd == CMD_WRITE && bank_q[link.bankAddr] != BANK_IDLE) begin
      wrLeft_q <= 3'(BURST_LEN);
      wrIdx_q  <= link.addr[MEM_IDX_W-1:0];
    end else if (wrLeft_q != '0) begin
      wrLeft_q <= wrLeft_q - 3'h1;
      wrIdx_q  <= wrIdx_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (wrLeft_q != '0) begin
      for (int l = 0; l < MASK_W; l++) begin
        if (!link.dataMask[l]) begin
          mem_q[wrIdx_q][l*8 +: 8] <= link.dqWire[l*8 +: 8];  // see [R9]
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registered outputs; the read path is not modelled so dq stays released
  always_ff @(posedge clock) begin
    if (!resetn) begin
      link.dqMemOe   <= 1'b0;
      link.dqFromMem <= '0;
    end else begin
      link.dqMemOe   <= 1'b0;
      link.dqFromMem <= mem_q[wrIdx_q];
    end
  end

  assign modeReg         = mode_q;
  assign extModeReg      = extMode_q;
  assign powerState      = {1'b0, power_q};
  assign autoPrechargeOn = ap_q;
  assign exitViolation   = exitViol_q;
  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      bankStates[2*b +: 2] = bank_q[b];
    end
  end

endmodule : lpddr_memory_end
`default_nettype wire

/* rtl/lpddr_controller_end.sv */
// memory controller end: turns user requests into link commands
// assumes the user waits for reqReady and keeps its own sequencing legal
`timescale 1ns/1ps
`default_nettype none
module lpddr_controller_end
  import lpddr_cmd_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  reqValid,
  input  wire logic [3:0]            reqCmd,
  input  wire logic                  reqCke,
  input  wire logic [BANK_W-1:0]     reqBank,
  input  wire logic [ADDR_W-1:0]     reqAddr,
  input  wire logic [DATA_W-1:0]     reqData,
  input  wire logic [MASK_W-1:0]     reqMask,
  output logic                       reqReady,
  lpddr_link_if.controller           link
);

  ////////////////////////////////////////////////////////////////////////
  // exit wait: after cke rises only nop goes out until the count ends
  logic                    ckeOut_q;
  logic [EXIT_CNT_W-1:0]   wait_q;
  logic                    readBurstNoAp_q;
  logic                    accept;
  logic                    exitStart;
  cmd_t                    userCmd;
  assign userCmd   = decodeCmd(reqCmd);
  // take only on ready, which mirrors the wait count, so no request slips in late
  assign accept    = reqValid && reqReady;
  assign exitStart = accept && !ckeOut_q && reqCke;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ckeOut_q <= 1'b1;
      wait_q   <= '0;
    end else begin
      if (wait_q != '0) begin
        wait_q <= wait_q - 1'b1;
      end
      if (accept) begin
        ckeOut_q <= reqCke;
        if (!ckeOut_q && reqCke) begin
          // self refresh wait covers both exits; longer is always safe
          wait_q <= EXIT_CNT_W'(SELF_REFRESH_EXIT_CYCLES);  // see [R14] [R15]
        end
      end
    end
  end

  // track open read without auto precharge so terminate stays legal
  always_ff @(posedge clock) begin
    if (!resetn) begin
      readBurstNoAp_q <= 1'b0;
    end else if (accept && userCmd == CMD_READ) begin
      readBurstNoAp_q <= !reqAddr[AP_BIT];
    end else if (accept && userCmd != CMD_NOP) begin
      readBurstNoAp_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write burst: data and mask go out on the four edges after the write pins
  logic [2:0]              wrLeft_q;
  logic [DATA_W-1:0]       wrData_q;
  logic [MASK_W-1:0]       wrMask_q;
  logic                    wrTake;
  assign wrTake = accept && userCmd == CMD_WRITE && reqCke && ckeOut_q;

  // data is latched at the take, so the user may move on before the burst ends
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrLeft_q <= '0;
      wrData_q <= '0;
      wrMask_q <= '1;
    end else if (wrTake) begin
      wrLeft_q <= 3'(BURST_LEN);
      wrData_q <= reqData;
      wrMask_q <= reqMask;
    end else if (wrLeft_q != '0) begin
      wrLeft_q <= wrLeft_q - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // drive pins from flops; exit edge and illegal terminate become nop
  always_ff @(posedge clock) begin
    if (!resetn) begin
      {link.chipSelectN, link.rasN, link.casN, link.weN} <= 4'h7;
      link.bankAddr   <= '0;
      link.addr       <= '0;
      link.dataMask   <= '1;
      link.dqFromCtrl <= '0;
      link.dqCtrlOe   <= 1'b0;
      link.clockEnable <= 1'b1;
      reqReady        <= 1'b0;
    end else begin
      // ready reflects the wait count as it will stand after this edge
      reqReady         <= !exitStart && (wait_q == '0 || wait_q == EXIT_CNT_W'(1));
      link.clockEnable <= accept ? reqCke : ckeOut_q;
      if (accept && !(!ckeOut_q && reqCke)                                // see [R12]
          && !(userCmd == CMD_TERMINATE && reqCke && !readBurstNoAp_q)) begin  // see [R2]
        {link.chipSelectN, link.rasN, link.casN, link.weN} <= reqCmd;  // see [R21] [R7]
      end else begin
        {link.chipSelectN, link.rasN, link.casN, link.weN} <= 4'h7;
      end
      link.bankAddr   <= reqBank;
      link.addr       <= reqAddr;
      link.dataMask   <= (wrLeft_q != '0) ? wrMask_q : '1;  // see [R9]
      link.dqFromCtrl <= wrData_q;
      link.dqCtrlOe   <= (wrLeft_q != '0);                 // see [R9]
    end
  end

  // clock pins follow the one clock; complement is its inverse
  assign link.clockP = clock;
  assign link.clockN = ~clock;

endmodule : lpddr_controller_end
`default_nettype wire

/* testbench/lpddr_cmd_monitor.sv */
// concurrent checks on the pins between controller end and memory end
// assumes one clock and a synchronous active-low reset shared by both ends
`timescale 1ns/1ps
`default_nettype none
module lpddr_cmd_monitor
  import lpddr_cmd_pkg::*;
(
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic              clockP,
  input wire logic              clockN,
  input wire logic              clockEnable,
  input wire logic              chipSelectN,
  input wire logic              rasN,
  input wire logic              casN,
  input wire logic              weN,
  input wire logic [MASK_W-1:0] dataMask,
  input wire logic [DATA_W-1:0] dqFromCtrl,
  input wire logic              dqCtrlOe,
  input wire logic              dqMemOe,
  input wire logic [DATA_W-1:0] dqWire
);
  //////////////////////////////////////////////////////////////////////////////
  // pin decode; deselect folds into nop as the memory end sees it
  logic isNop;
  logic isWrite;
  logic entryOk;
  assign isNop   = chipSelectN | (rasN & casN & weN);
  assign isWrite = clockEnable & ~chipSelectN & rasN & ~casN & ~weN;
  assign entryOk = isNop | ({chipSelectN, rasN, casN, weN} == CMD_REFRESH)
                 | ({chipSelectN, rasN, casN, weN} == CMD_TERMINATE);

  //////////////////////////////////////////////////////////////////////////////
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_reset_pins_idle: assert property (
    $rose(resetn) |-> clockEnable && isNop && dataMask == '1)
    else $error("link not idle after reset");
  a_diff_clock_pair: assert property (clockN == ~clockP)
    else $error("clock pair not complementary");
  a_entry_cmd_legal: assert property ($fell(clockEnable) |-> entryOk)
    else $error("low power entry with illegal command");
  a_exit_wait_quiet: assert property ($rose(clockEnable) |-> isNop [*3])
    else $error("command during low power exit");
  a_write_burst_oe: assert property (isWrite |=> dqCtrlOe [*4])
    else $error("write burst data not driven");
  a_oe_needs_write: assert property ($rose(dqCtrlOe) |-> $past(isWrite))
    else $error("data driven without write");
  a_wire_follows_ctrl: assert property (dqCtrlOe |-> dqWire == dqFromCtrl)
    else $error("data wire differs from controller");
  a_mem_never_drives: assert property (dqCtrlOe |-> !dqMemOe)
    else $error("memory drives during write data");

  // main traffic kinds, to show the bench reached them
  c_write_seen: cover property (isWrite);
  c_power_entry: cover property ($fell(clockEnable));
  c_power_exit: cover property ($rose(clockEnable));
endmodule : lpddr_cmd_monitor
`default_nettype wire

/* testbench/lpddr_command_state_logic_tb.sv */
// bench joining controller end and memory end through the link interface
// assumes the package constants and the hand-over timing of both ends
`timescale 1ns/1ps
`default_nettype none
module lpddr_command_state_logic_tb;
  import lpddr_cmd_pkg::*;
  logic                 clock;
  logic                 resetn;
  logic                 reqValid;
  logic [3:0]           reqCmd;
  logic                 reqCke;
  logic [BANK_W-1:0]    reqBank;
  logic [ADDR_W-1:0]    reqAddr;
  logic [DATA_W-1:0]    reqData;
  logic [MASK_W-1:0]    reqMask;
  logic                 reqReady;
  logic [ADDR_W-1:0]    modeReg;
  logic [ADDR_W-1:0]    extModeReg;
  logic [3:0]           powerState;
  logic [2*BANKS-1:0]   bankStates;
  logic [BANKS-1:0]     autoPrechargeOn;
  logic                 exitViolation;
  int                   n_mismatch;
  int                   n_compared;

  //////////////////////////////////////////////////////////////////////////////
  // both ends face each other; the monitor watches the wire between them
  lpddr_link_if link ();
  lpddr_controller_end i_lpddr_controller_end (.clock(clock), .resetn(resetn),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqCke(reqCke), .reqBank(reqBank),
    .reqAddr(reqAddr), .reqData(reqData), .reqMask(reqMask),
    .reqReady(reqReady), .link(link));
  lpddr_memory_end i_lpddr_memory_end (.clock(clock), .resetn(resetn),
    .link(link), .modeReg(modeReg), .extModeReg(extModeReg),
    .powerState(powerState), .bankStates(bankStates),
    .autoPrechargeOn(autoPrechargeOn), .exitViolation(exitViolation));
  lpddr_cmd_monitor i_lpddr_cmd_monitor (.clock(clock), .resetn(resetn),
    .clockP(link.clockP), .clockN(link.clockN), .clockEnable(link.clockEnable),
    .chipSelectN(link.chipSelectN), .rasN(link.rasN), .casN(link.casN),
    .weN(link.weN), .dataMask(link.dataMask), .dqFromCtrl(link.dqFromCtrl),
    .dqCtrlOe(link.dqCtrlOe), .dqMemOe(link.dqMemOe), .dqWire(link.dqWire));

  //////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one request; held until taken, then settles two cycles past the pins
  task automatic send(input logic [3:0] c, input logic k, input logic [1:0] b,
                      input logic [12:0] a);
    int n;
    n = 0;
    @(posedge clock);
    reqValid <= 1'b1;
    reqCmd   <= c;
    reqCke   <= k;
    reqBank  <= b;
    reqAddr  <= a;
    reqData  <= {a[7:0], ~a[7:0]};
    reqMask  <= a[12:11];
    @(negedge clock);
    while (reqReady !== 1'b1 && n < 64) begin
      @(negedge clock);
      n++;
    end
    if (n == 64) n_mismatch++;
    @(posedge clock);
    reqValid <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    checkVal(powerState, {1'b0, PWR_ON});
    checkVal(bankStates, 8'h00);
    checkVal(modeReg, MODE_RESET);
    checkVal(extModeReg, EXT_MODE_RESET);
    $display("reset test done");
  endtask

  task automatic t_mode_set();
    send(CMD_MODE_SET, 1'b1, MRS_BASE_SEL, 13'h0032);
    checkVal(modeReg, 13'h0032);
    send(CMD_MODE_SET, 1'b1, MRS_EXT_SEL, 13'h0021);
    checkVal(extModeReg, 13'h0021);
    checkVal(modeReg, 13'h0032);
    $display("mode set test done");
  endtask

  // reads and writes chase each other in one open bank
  task automatic t_bank_flow();
    send(CMD_ACTIVATE, 1'b1, 2'h1, 13'h0123);
    checkVal(bankStates, {BANK_IDLE, BANK_IDLE, BANK_ACTIVE, BANK_IDLE});
    send(CMD_DESELECT, 1'b1, 2'h1, 13'h0000);
    checkVal(bankStates, {BANK_IDLE, BANK_IDLE, BANK_ACTIVE, BANK_IDLE});
    send(CMD_READ, 1'b1, 2'h1, 13'h0004);
    checkVal(bankStates, {BANK_IDLE, BANK_IDLE, BANK_READ, BANK_IDLE});
    checkVal(autoPrechargeOn, 4'h0);
    send(CMD_WRITE, 1'b1, 2'h1, 13'h1808);
    checkVal(bankStates, {BANK_IDLE, BANK_IDLE, BANK_WRITE, BANK_IDLE});
    send(CMD_READ, 1'b1, 2'h1, 13'h000C);
    checkVal(bankStates, {BANK_IDLE, BANK_IDLE, BANK_READ, BANK_IDLE});
    send(CMD_TERMINATE, 1'b1, 2'h1, 13'h0000);
    checkVal(bankStates, {BANK_IDLE, BANK_IDLE, BANK_ACTIVE, BANK_IDLE});
    send(CMD_WRITE, 1'b1, 2'h1, 13'h0402);
    checkVal(bankStates, 8'h00);
    checkVal(autoPrechargeOn, 4'h2);
    $display("bank flow test done");
  endtask

  task automatic t_precharge();
    send(CMD_ACTIVATE, 1'b1, 2'h0, 13'h0010);
    send(CMD_ACTIVATE, 1'b1, 2'h2, 13'h0020);
    send(CMD_PRECHARGE, 1'b1, 2'h0, 13'h0000);
    checkVal(bankStates, {BANK_IDLE, BANK_ACTIVE, BANK_IDLE, BANK_IDLE});
    send(CMD_PRECHARGE, 1'b1, 2'h1, 13'h0400);
    checkVal(bankStates, 8'h00);
    $display("precharge test done");
  endtask

  task automatic t_power();
    send(CMD_NOP, 1'b0, 2'h0, 13'h0000);
    checkVal(powerState, {1'b0, PWR_PRE_DOWN});
    send(CMD_ACTIVATE, 1'b0, 2'h0, 13'h0055);
    checkVal(powerState, {1'b0, PWR_PRE_DOWN});
    checkVal(bankStates, 8'h00);
    send(CMD_NOP, 1'b1, 2'h0, 13'h0000);
    checkVal(powerState, {1'b0, PWR_ON});
    checkVal(reqReady, 1'b0);
    send(CMD_ACTIVATE, 1'b1, 2'h3, 13'h0077);
    send(CMD_NOP, 1'b0, 2'h0, 13'h0000);
    checkVal(powerState, {1'b0, PWR_ACT_DOWN});
    send(CMD_NOP, 1'b1, 2'h0, 13'h0000);
    send(CMD_PRECHARGE, 1'b1, 2'h0, 13'h0400);
    checkVal(powerState, {1'b0, PWR_ON});
    $display("power down test done");
  endtask

  // refresh with junk on address and bank pins
  task automatic t_refresh();
    send(CMD_REFRESH, 1'b1, 2'h3, 13'h1FFF);
    checkVal(powerState, {1'b0, PWR_ON});
    checkVal(bankStates, 8'h00);
    checkVal(modeReg, 13'h0032);
    send(CMD_REFRESH, 1'b0, 2'h2, 13'h1ABC);
    checkVal(powerState, {1'b0, PWR_SELF_REF});
    send(CMD_NOP, 1'b1, 2'h0, 13'h0000);
    checkVal(powerState, {1'b0, PWR_ON});
    checkVal(reqReady, 1'b0);
    checkVal(exitViolation, 1'b0);
    $display("refresh test done");
  endtask

  // last scenario: deep exit is not counted by the memory end; the controller still holds the self refresh wait
  task automatic t_deep();
    send(CMD_TERMINATE, 1'b0, 2'h0, 13'h0000);
    checkVal(powerState, {1'b0, PWR_DEEP_DOWN});
    checkVal(extModeReg, EXT_MODE_RESET);
    send(CMD_NOP, 1'b1, 2'h0, 13'h0000);
    checkVal(powerState, {1'b0, PWR_ON});
    $display("deep power down test done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    resetn     = 1'b0;
    reqValid   = 1'b0;
    reqCmd     = CMD_NOP;
    reqCke     = 1'b1;
    reqBank    = 2'h0;
    reqAddr    = 13'h0000;
    reqData    = 16'h0000;
    reqMask    = 2'h3;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    t_reset();
    t_mode_set();
    t_bank_flow();
    t_precharge();
    t_power();
    t_refresh();
    t_deep();
    stop_test();
  end

  // watchdog, well past the hundred-odd cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    stop_test();
  end
endmodule : lpddr_command_state_logic_tb
`default_nettype wire
